// file: core/itt_map.svh
// Register indices, field positions, reset values and tap counts.
`ifndef ITT_MAP_SVH
`define ITT_MAP_SVH

// Register indices; the byte address is four times the index.
`define ITT_MODE_IDX        16'hFFC0
`define ITT_COUNT_IDX       16'hFFC1
`define ITT_STATUS_IDX      16'hFFF0
`define ITT_MASK_IDX        16'hFFF1

// Mode register fields.
`define ITT_MODE_RSVD       8'hF0
`define ITT_MODE_RESET      4'h0
`define ITT_SRC_BIT         3
`define ITT_RATE_MSB        2

// Interrupt fields: bit 0 is the overflow event in both registers.
`define ITT_OVF_BIT         0

// Counter and prescaler reset values, and the counter's top value.
`define ITT_COUNT_RESET     8'h00
`define ITT_COUNT_MAX       8'hFF
`define ITT_SYSP_RESET      13'h0000
`define ITT_SUBP_RESET      5'h00

// Divider exponents of each prescaler tap, in rate-field order.
`define ITT_SYSP_TAPS       '{13, 12, 11, 9, 8, 7, 5, 3}
`define ITT_SUBP_TAPS       '{5, 4, 3, 1}

// AXI responses.
`define ITT_RESP_OKAY       2'h0
`define ITT_RESP_SLVERR     2'h2

`endif

// file: core/itt_pkg.sv
// Types shared by the interval and time-base timer.
package itt_pkg;

   typedef enum logic [1:0] {
      MODE_INTERVAL,
      MODE_TIMEBASE,
      MODE_INIT
   } mode_e;

   typedef logic [7:0]  count_t;
   typedef logic [12:0] sysp_t;
   typedef logic [4:0]  subp_t;
   typedef logic [1:0]  resp_t;

endpackage : itt_pkg

// file: core/interval_timebase_timer.sv
// Interval and time-base timer with an AXI4-Lite register slave.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "itt_map.svh"

module interval_timebase_timer #(
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // Subclock and low-power status
   input  wire logic                subclk,
   input  wire logic                sys_clk_halt,
   // AXI4-Lite write address
   input  wire logic                awvalid,
   output      logic                awready,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic [2:0]          awprot,
   // AXI4-Lite write data
   input  wire logic                wvalid,
   output      logic                wready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   // AXI4-Lite write response
   output      logic                bvalid,
   input  wire logic                bready,
   output      itt_pkg::resp_t      bresp,
   // AXI4-Lite read address
   input  wire logic                arvalid,
   output      logic                arready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic [2:0]          arprot,
   // AXI4-Lite read data
   output      logic                rvalid,
   input  wire logic                rready,
   output      logic [31:0]         rdata,
   output      itt_pkg::resp_t      rresp,
   // Interrupt
   output      logic                irq
);
   import itt_pkg::*;

   // The index needs sixteen bits above the two byte-offset bits.
   if (ADDR_W < 18) begin : g_addr_check
      $error("ADDR_W must be at least 18");
   end

   localparam int IDX_W = ADDR_W - 2;
   localparam logic [IDX_W-1:0] MODE_IDX   = IDX_W'(`ITT_MODE_IDX);
   localparam logic [IDX_W-1:0] COUNT_IDX  = IDX_W'(`ITT_COUNT_IDX);
   localparam logic [IDX_W-1:0] STATUS_IDX = IDX_W'(`ITT_STATUS_IDX);
   localparam logic [IDX_W-1:0] MASK_IDX   = IDX_W'(`ITT_MASK_IDX);
   localparam int SYSP_TAP [8] = `ITT_SYSP_TAPS;
   localparam int SUBP_TAP [4] = `ITT_SUBP_TAPS;

   // =====================================================================
   // State
   // =====================================================================
   logic [3:0]         mode_q;
   count_t             count_q;
   sysp_t              sysp_q;
   subp_t              subp_q;
   logic               subclk_q;
   logic               ovf_flag_q;
   logic               ovf_en_q;
   logic               irq_q;

   logic               aw_hold_q;
   logic [IDX_W-1:0]   aw_idx_q;
   logic               w_hold_q;
   logic [31:0]        w_data_q;
   logic               w_strb0_q;
   logic               awready_q;
   logic               wready_q;
   logic               bvalid_q;
   resp_t              bresp_q;
   logic               arready_q;
   logic               rvalid_q;
   logic [31:0]        rdata_q;
   resp_t              rresp_q;

   // =====================================================================
   // Mode decode
   // =====================================================================
   mode_e              mode;
   logic               src_sub;
   logic               rate_msb;

   assign src_sub  = mode_q[`ITT_SRC_BIT];
   assign rate_msb = mode_q[`ITT_RATE_MSB];
   // Both bits set is the count-initialization state.
   assign mode = (src_sub && rate_msb) ? MODE_INIT :
                 src_sub ? MODE_TIMEBASE : MODE_INTERVAL;

   // =====================================================================
   // Prescalers
   // =====================================================================
   // The subclock is a slow level taken as synchronous; its rising edge
   // is the prescaler's count event, which keeps one clock domain.
   logic               subp_inc;
   logic               sysp_inc;
   logic [7:0]         sysp_tick;
   logic [3:0]         subp_tick;

   assign subp_inc = subclk && !subclk_q;
   assign sysp_inc = !sys_clk_halt;

   // A tap of 2^k ticks when the low k bits are all one and the
   // prescaler steps, which is the carry out of that bit.
   for (genvar i = 0; i < 8; i++) begin : g_sysp_tap
      assign sysp_tick[i] = sysp_inc &&
                            (&sysp_q[SYSP_TAP[i]-1:0]);
   end
   for (genvar j = 0; j < 4; j++) begin : g_subp_tap
      assign subp_tick[j] = subp_inc &&
                            (&subp_q[SUBP_TAP[j]-1:0]);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sysp_q <= `ITT_SYSP_RESET;
      end else if (!sysp_inc) begin
         sysp_q <= `ITT_SYSP_RESET;
      end else begin
         sysp_q <= sysp_q + 13'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         subclk_q <= 1'b0;
         subp_q   <= `ITT_SUBP_RESET;
      end else begin
         subclk_q <= subclk;
         if (mode == MODE_INIT) begin
            subp_q <= `ITT_SUBP_RESET;
         end else if (subp_inc) begin
            subp_q <= subp_q + 5'h01;
         end
      end
   end

   // =====================================================================
   // Counter
   // =====================================================================
   logic               tick;
   logic               ovf;

   always_comb begin
      unique case (mode)
         MODE_INTERVAL: tick = sysp_tick[mode_q[2:0]];
         MODE_TIMEBASE: tick = subp_tick[mode_q[1:0]];
         MODE_INIT:     tick = 1'b0;
      endcase
   end

   assign ovf = tick && (count_q == `ITT_COUNT_MAX);

   // Leaving the initialized state needs no special step: the counter
   // already sits at zero and simply resumes on the next tick.
   always_ff @(posedge clk) begin
      if (srst) begin
         count_q <= `ITT_COUNT_RESET;
      end else if (mode == MODE_INIT) begin
         count_q <= `ITT_COUNT_RESET;
      end else if (tick) begin
         count_q <= count_q + 8'h01;
      end
   end

   // =====================================================================
   // Write channel
   // =====================================================================
   logic               aw_take;
   logic               w_take;
   logic               do_wr;
   logic               b_done;
   logic               wr_mode;
   logic               wr_count;
   logic               wr_status;
   logic               wr_mask;
   logic               wr_hit;
   logic               ovf_clr;

   assign aw_take   = awvalid && awready_q;
   assign w_take    = wvalid && wready_q;
   assign do_wr     = aw_hold_q && w_hold_q && !bvalid_q;
   assign b_done    = bvalid_q && bready;
   assign wr_mode   = do_wr && (aw_idx_q == MODE_IDX);
   assign wr_count  = do_wr && (aw_idx_q == COUNT_IDX);
   assign wr_status = do_wr && (aw_idx_q == STATUS_IDX);
   assign wr_mask   = do_wr && (aw_idx_q == MASK_IDX);
   assign wr_hit    = wr_mode || wr_count || wr_status || wr_mask;
   assign ovf_clr   = wr_status && w_strb0_q && w_data_q[`ITT_OVF_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         aw_hold_q <= 1'b0;
         aw_idx_q  <= '0;
         awready_q <= 1'b1;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            aw_idx_q  <= awaddr[ADDR_W-1:2];
            awready_q <= 1'b0;
         end else if (do_wr) begin
            aw_hold_q <= 1'b0;
         end
         if (b_done) begin
            awready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         w_hold_q  <= 1'b0;
         w_data_q  <= '0;
         w_strb0_q <= 1'b0;
         wready_q  <= 1'b1;
      end else begin
         if (w_take) begin
            w_hold_q  <= 1'b1;
            w_data_q  <= wdata;
            w_strb0_q <= wstrb[0];
            wready_q  <= 1'b0;
         end else if (do_wr) begin
            w_hold_q <= 1'b0;
         end
         if (b_done) begin
            wready_q <= 1'b1;
         end
      end
   end

   // A write to the counter is accepted and ignored.
   always_ff @(posedge clk) begin
      if (srst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `ITT_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? `ITT_RESP_OKAY : `ITT_RESP_SLVERR;
      end else if (b_done) begin
         bvalid_q <= 1'b0;
      end
   end

   // =====================================================================
   // Registers
   // =====================================================================
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q   <= `ITT_MODE_RESET;
         ovf_en_q <= 1'b0;
      end else begin
         if (wr_mode && w_strb0_q) begin
            mode_q <= w_data_q[3:0];
         end
         if (wr_mask && w_strb0_q) begin
            ovf_en_q <= w_data_q[`ITT_OVF_BIT];
         end
      end
   end

   // A new overflow in the cycle of a clear wins, so none is lost.
   always_ff @(posedge clk) begin
      if (srst) begin
         ovf_flag_q <= 1'b0;
      end else if (ovf) begin
         ovf_flag_q <= 1'b1;
      end else if (ovf_clr) begin
         ovf_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (ovf_flag_q || ovf) && ovf_en_q;
      end
   end

   // =====================================================================
   // Read channel
   // =====================================================================
   logic               ar_take;
   logic               r_done;
   logic [IDX_W-1:0]   ar_idx;
   logic               rd_mode;
   logic               rd_count;
   logic               rd_status;
   logic               rd_mask;
   logic               rd_hit;
   logic [31:0]        rd_data;

   assign ar_take   = arvalid && arready_q;
   assign r_done    = rvalid_q && rready;
   assign ar_idx    = araddr[ADDR_W-1:2];
   assign rd_mode   = ar_idx == MODE_IDX;
   assign rd_count  = ar_idx == COUNT_IDX;
   assign rd_status = ar_idx == STATUS_IDX;
   assign rd_mask   = ar_idx == MASK_IDX;
   assign rd_hit    = rd_mode || rd_count || rd_status || rd_mask;
   assign rd_data   =
      rd_mode   ? {24'h000000, `ITT_MODE_RSVD | {4'h0, mode_q}} :
      rd_count  ? {24'h000000, count_q} :
      rd_status ? {31'h00000000, ovf_flag_q} :
      rd_mask   ? {31'h00000000, ovf_en_q} :
                  32'h00000000;

   // Reading the counter only samples it; counting goes on untouched.
   always_ff @(posedge clk) begin
      if (srst) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `ITT_RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_data;
         rresp_q   <= rd_hit ? `ITT_RESP_OKAY : `ITT_RESP_SLVERR;
      end else if (r_done) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign irq     = irq_q;

endmodule : interval_timebase_timer

// file: testbench/itt_props.sv
// Port-level assertions for the interval and time-base timer.
`timescale 1ns/1ps

module itt_props (
   // Clock and reset
   input wire logic           clk,
   input wire logic           srst,
   // Write channels
   input wire logic           awvalid,
   input wire logic           awready,
   input wire logic           wvalid,
   input wire logic           wready,
   input wire logic           bvalid,
   input wire logic           bready,
   input wire itt_pkg::resp_t bresp,
   // Read channels
   input wire logic           arvalid,
   input wire logic           arready,
   input wire logic           rvalid,
   input wire logic           rready,
   input wire logic [31:0]    rdata,
   input wire itt_pkg::resp_t rresp,
   // Interrupt
   input wire logic           irq
);
   import itt_pkg::*;

   // ==========================================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   property p_rel_idle; $fell(srst) |-> !rvalid && !bvalid && !irq; endproperty
   a_rel_idle: assert property (p_rel_idle)
      else $error("outputs busy after reset");
   property p_rd_ans; arvalid && arready |=> rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read answer late");
   property p_rd_end; rvalid && rready |=> !rvalid; endproperty
   a_rd_end: assert property (p_rd_end)
      else $error("read answer repeated");
   property p_ar_busy; rvalid |-> !arready; endproperty
   a_ar_busy: assert property (p_ar_busy)
      else $error("read taken while answering");
   property p_wr_ans;
      awvalid && awready && wvalid && wready |-> ##1 !bvalid ##1 bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write answer timing");
   property p_wr_busy; bvalid |-> !awready && !wready; endproperty
   a_wr_busy: assert property (p_wr_busy)
      else $error("write taken while answering");
   property p_irq_fall; $fell(irq) |-> $past(bvalid); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without a write");
   property p_err_zero;
      rvalid && rresp == resp_t'(2'h2) |-> rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero)
      else $error("refused read carries data");

   c_irq: cover property ($rose(irq));
   c_berr: cover property (bvalid && bresp == resp_t'(2'h2));
   c_rd: cover property (rvalid && rready);
endmodule : itt_props

bind interval_timebase_timer itt_props i_props (
   .clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
   .irq(irq));

// file: testbench/tb.sv
// Self-checking bench for the interval and time-base timer.
`timescale 1ns/1ps
`include "itt_map.svh"

module tb;
   import itt_pkg::*;

   localparam logic [17:0] MODE_ADR = {`ITT_MODE_IDX, 2'h0};
   localparam logic [17:0] CNT_ADR  = {`ITT_COUNT_IDX, 2'h0};
   localparam logic [17:0] STAT_ADR = {`ITT_STATUS_IDX, 2'h0};
   localparam logic [17:0] MASK_ADR = {`ITT_MASK_IDX, 2'h0};
   localparam logic [17:0] BAD_ADR  = 18'h00010;
   localparam int          SYSP_K[8] = `ITT_SYSP_TAPS;
   localparam int          SUBP_K[4] = `ITT_SUBP_TAPS;

   logic        clk, srst, sys_clk_halt;
   logic        subclk = 1'b0;
   logic [2:0]  sub_cnt = 3'h0;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid;
   logic        arvalid, arready, rvalid, irq;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   resp_t       bresp, rresp;
   int          n_fail = 0;
   int          num_checks = 0;

   interval_timebase_timer i_dut (
      .clk(clk), .srst(srst), .subclk(subclk),
      .sys_clk_halt(sys_clk_halt), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(1'b1),
      .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1),
      .rdata(rdata), .rresp(rresp), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The subclock runs free at an eighth of the system clock.
   always @(posedge clk) begin
      sub_cnt <= sub_cnt + 3'h1;
      subclk  <= sub_cnt[2];
   end

   // ==========================================================
   // Bus tasks
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [17:0] a, input logic [31:0] d,
                     input resp_t er);
      int i;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (!awvalid && !wvalid && bvalid) break;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      if (i < 100) chk(32'(bresp), 32'(er), "write response");
      else begin
         n_fail++;
         wrap_up();
      end
   endtask : wr

   task automatic rd(input logic [17:0] a, output logic [31:0] d,
                     output resp_t r);
      int i;
      araddr  <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (!arvalid && rvalid) break;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      if (i < 100) begin
         d = rdata;
         r = rresp;
      end else begin
         n_fail++;
         wrap_up();
      end
   endtask : rd

   task automatic rc(input logic [17:0] a, input logic [31:0] e,
                     input string what);
      logic [31:0] d;
      resp_t       r;
      rd(a, d, r);
      chk(d, e, what);
   endtask : rc

   // ==========================================================
   // Scenarios
   initial begin
      logic [31:0] c0, c1;
      resp_t       r;
      int          i;
      int          k;
      srst         = 1'b1;
      sys_clk_halt = 1'b0;
      wstrb        = 4'hF;
      awvalid      = 1'b0;
      wvalid       = 1'b0;
      arvalid      = 1'b0;
      awaddr       = '0;
      araddr       = '0;
      wdata        = '0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rc(MODE_ADR, 32'h0000_00F0, "mode");
      rc(CNT_ADR, 32'h0, "count");
      rc(STAT_ADR, 32'h0, "status");
      rc(MASK_ADR, 32'h0, "mask");
      wr(MODE_ADR, 32'h0000_000A, `ITT_RESP_OKAY);
      rc(MODE_ADR, 32'h0000_00FA, "mode");
      // A write with lane 0 not strobed is answered but has no effect.
      wstrb <= 4'h0;
      wr(MODE_ADR, 32'h0000_0003, `ITT_RESP_OKAY);
      wstrb <= 4'hF;
      rc(MODE_ADR, 32'h0000_00FA, "unstrobed mode");
      wr(MODE_ADR, 32'h0000_000C, `ITT_RESP_OKAY);
      wr(CNT_ADR, 32'h0000_0055, `ITT_RESP_OKAY);
      repeat (40) @(posedge clk);
      rc(CNT_ADR, 32'h0, "held count");
      wr(BAD_ADR, 32'h0000_0001, `ITT_RESP_SLVERR);
      rd(BAD_ADR, c0, r);
      chk(32'(r), 32'(`ITT_RESP_SLVERR), "read response");
      // Reads spaced by four tap periods see exactly four steps.
      for (k = 0; k < 8; k++) begin
         wr(MODE_ADR, 32'(k), `ITT_RESP_OKAY);
         rd(CNT_ADR, c0, r);
         repeat (4 * (1 << SYSP_K[k]) - 2) @(posedge clk);
         rd(CNT_ADR, c1, r);
         chk((c1 - c0) & 32'hFF, 32'h4, "interval steps");
      end
      sys_clk_halt <= 1'b1;
      @(posedge clk);
      rd(CNT_ADR, c0, r);
      repeat (100) @(posedge clk);
      rc(CNT_ADR, c0, "halted count");
      sys_clk_halt <= 1'b0;
      for (k = 0; k < 4; k++) begin
         wr(MODE_ADR, 32'h0000_000C, `ITT_RESP_OKAY);
         wr(MODE_ADR, 32'(8 + k), `ITT_RESP_OKAY);
         repeat (24 * (1 << SUBP_K[k]) + 4) @(posedge clk);
         rc(CNT_ADR, 32'h3, "time-base steps");
      end
      wr(MODE_ADR, 32'h0000_000C, `ITT_RESP_OKAY);
      wr(MODE_ADR, 32'h0000_0005, `ITT_RESP_OKAY);
      rd(CNT_ADR, c0, r);
      chk(c0 & 32'hFE, 32'h0, "count after init");
      wr(MODE_ADR, 32'h0000_000C, `ITT_RESP_OKAY);
      wr(MODE_ADR, 32'h0000_0007, `ITT_RESP_OKAY);
      for (i = 0; i < 2000; i++) begin
         rd(STAT_ADR, c0, r);
         if (c0[0] === 1'b1) break;
      end
      chk(c0, 32'h1, "overflow flag");
      chk({31'h0, irq}, 32'h0, "masked irq");
      rd(CNT_ADR, c1, r);
      chk(c1 & 32'hFE, 32'h0, "wrapped count");
      wr(STAT_ADR, 32'h0, `ITT_RESP_OKAY);
      wr(MASK_ADR, 32'h1, `ITT_RESP_OKAY);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1, "enabled irq");
      wr(MASK_ADR, 32'h0, `ITT_RESP_OKAY);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(MASK_ADR, 32'h1, `ITT_RESP_OKAY);
      wr(STAT_ADR, 32'h1, `ITT_RESP_OKAY);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0, "cleared irq");
      rc(STAT_ADR, 32'h0, "status");
      wrap_up();
   end
endmodule : tb
